// ===== lesar_pkg.sv
// Purpose: constants and carrier types for the link enhancement / subsystem alias registers
// Assumes: 32-bit configuration dword access with byte enables
// Notes: link enhancement offset has no printed value here and is a fixed package localparam
package lesar_pkg;
  localparam logic [11:0] lesar_ofs_subsys = 12'h0f8;
  localparam logic [11:0] lesar_ofs_link_enh = 12'h0f4;
  localparam int lesar_bit_mpeg = 10;
  localparam int lesar_bit_dv = 8;
  localparam int lesar_bit_prio = 7;
  localparam int lesar_bit_rsvd2 = 2;
  localparam int lesar_bit_accel = 1;
  localparam logic [31:0] lesar_enh_wmask = 32'h0000_0586;
  localparam logic [31:0] lesar_enh_reset = 32'h0000_0000;
  localparam logic [31:0] lesar_subsys_reset = 32'h0000_0000;
  localparam logic [7:0] lesar_fmt_mpeg = 8'h20;
  localparam logic [7:0] lesar_fmt_dv = 8'h00;

  // configuration cycle request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } lesar_cfg_req_t;

  // enhancement controls that steer the link
  typedef struct packed {
    logic mpeg_stamp_boost_on;
    logic dv_stamp_boost_on;
    logic prio_req_on;
    logic accel_on;
    logic rsvd2;
  } lesar_enh_t;
endpackage

// ===== lesar_reg32.sv
// Purpose: one 32-bit register with byte-lane write and write mask
// Assumes: reset is the synchronous fundamental reset only
// Notes: read data comes straight from the register
`timescale 1ns/1ps
module lesar_reg32 import lesar_pkg::*; #(
  parameter logic [31:0] reset_value = 32'h0000_0000,
  parameter logic [31:0] wmask = 32'hffff_ffff
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write side
  input wire logic we,
  input wire logic [3:0] be,
  input wire logic [31:0] wdata,
  // value
  output logic [31:0] q
);
  logic [31:0] next_q;
  logic [31:0] lane;

  // per-byte merge of masked write bits
  always_comb begin
    lane = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    next_q = q;
    if (we) begin
      next_q = (q & ~lane) | (wdata & lane);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= reset_value;
    end else begin
      q <= next_q;
    end
  end
endmodule // lesar_reg32

// ===== lesar_regs.sv
// Purpose: link enhancement control low half and subsystem access alias registers
// Assumes: configuration requests synchronous to clk, one cycle each
// Notes: both registers cleared only by the fundamental reset
//
// Overview of operation
// [R1] bit 10 set enables timestamp enhancement for MPEG transmit streams, format 20h
// [R2] bit 8 set enables timestamp enhancement for DV transmit streams, format 00h
// [R3] bit 7 set makes the link answer asynchronous requests with priority arbitration
// [R4] bit 1 set tells the PHY the link supports acceleration enhancements
// [R5] software keeps writable reserved bit 2 at zero
// [R6] reserved bits 9, 6 to 3 and 0 read as zero
// [R7] writable enhancement bits 10, 8, 7, 2, 1 reset to zero
// [R8] subsystem access write also updates the function's subsystem ID registers
// [R9] subsystem access reads return the last written value
// [R10] device alias in bits 31 to 16, vendor alias in bits 15 to 0
// [R11] these bits cleared only by fundamental reset, kept through other resets
// [R12] fundamental reset asserted when PCIe reset or global reset is asserted
// [R13] writes to read-only reserved bits are ignored, bits stay zero
`timescale 1ns/1ps
module lesar_regs import lesar_pkg::*; (
  // clock and resets
  input wire logic clk,
  input wire logic nrst,
  input wire logic pcie_reset_n,
  input wire logic global_reset_n,
  // configuration access
  input wire lesar_cfg_req_t cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rvalid,
  // transmit stream format for timestamp qualification
  input wire logic [7:0] tx_fmt,
  // controls toward link and PHY
  output lesar_enh_t enh,
  output logic mpeg_stamp_apply,
  output logic dv_stamp_apply,
  // subsystem ID mirror toward the 1394 function
  output logic [15:0] subsystem_device_alias,
  output logic [15:0] subsystem_vendor_alias,
  output logic subsys_update,
  output logic fundamental_reset_n
);
  typedef struct packed {
    logic [31:0] rdata;
    logic rvalid;
    lesar_enh_t enh;
    logic mpeg_apply;
    logic dv_apply;
    logic [31:0] alias_q;
    logic upd;
    logic fundamental_reset_n_n;
  } lesar_state_t;

  lesar_state_t st;
  lesar_state_t next_st;
  logic [31:0] enh_q;
  logic [31:0] sub_q;
  logic hit_enh;
  logic hit_sub;

  assign hit_enh = cfg_req.addr == lesar_ofs_link_enh;
  assign hit_sub = cfg_req.addr == lesar_ofs_subsys;

  // enhancement register, only writable bits stored
  lesar_reg32 #(.reset_value(lesar_enh_reset), .wmask(lesar_enh_wmask)) u_enh ( // R7 R13
    .clk(clk),
    .rst_n(fundamental_reset_n), // R11
    .we(cfg_req.wr && hit_enh),
    .be(cfg_req.be),
    .wdata(cfg_req.wdata),
    .q(enh_q)
  );

  // subsystem access register, fully writable
  lesar_reg32 #(.reset_value(lesar_subsys_reset), .wmask(32'hffff_ffff)) u_sub ( // R10
    .clk(clk),
    .rst_n(fundamental_reset_n), // R11
    .we(cfg_req.wr && hit_sub),
    .be(cfg_req.be),
    .wdata(cfg_req.wdata),
    .q(sub_q)
  );

  // next state: read mux, decoded controls, alias mirror
  always_comb begin
    next_st = st;
    next_st.fundamental_reset_n_n = pcie_reset_n & global_reset_n; // R12
    next_st.rvalid = cfg_req.rd;
    next_st.rdata = 32'h0000_0000;
    if (cfg_req.rd && hit_enh) begin
      next_st.rdata = enh_q & lesar_enh_wmask; // R6
    end else if (cfg_req.rd && hit_sub) begin
      next_st.rdata = sub_q; // R9
    end
    next_st.enh.mpeg_stamp_boost_on = enh_q[lesar_bit_mpeg];
    next_st.enh.dv_stamp_boost_on = enh_q[lesar_bit_dv];
    next_st.enh.prio_req_on = enh_q[lesar_bit_prio]; // R3
    next_st.enh.accel_on = enh_q[lesar_bit_accel]; // R4
    next_st.enh.rsvd2 = enh_q[lesar_bit_rsvd2]; // R5
    next_st.mpeg_apply = enh_q[lesar_bit_mpeg] && tx_fmt == lesar_fmt_mpeg; // R1
    next_st.dv_apply = enh_q[lesar_bit_dv] && tx_fmt == lesar_fmt_dv; // R2
    next_st.alias_q = sub_q; // R8
    next_st.upd = cfg_req.wr && hit_sub;
  end

  // state register; fundamental reset itself is re-derived every cycle while nrst is high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else if (!fundamental_reset_n) begin
      st <= '0;
      st.fundamental_reset_n_n <= next_st.fundamental_reset_n_n;
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rdata = st.rdata;
  assign cfg_rvalid = st.rvalid;
  assign enh = st.enh;
  assign mpeg_stamp_apply = st.mpeg_apply;
  assign dv_stamp_apply = st.dv_apply;
  assign subsystem_device_alias = st.alias_q[31:16];
  assign subsystem_vendor_alias = st.alias_q[15:0];
  assign subsys_update = st.upd;
  assign fundamental_reset_n = st.fundamental_reset_n_n;

  // reserved read bits always zero
  rsvd_zero_a: assert property (@(posedge clk) disable iff (!nrst) // R6
    cfg_rvalid |-> (cfg_rdata & ~lesar_enh_wmask) == 32'h0 || $past(hit_sub))
    else $error("reserved enhancement bits read nonzero");
  // fundamental reset follows either reset input
  fundamental_reset_n_follow_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    !$past(pcie_reset_n) || !$past(global_reset_n) |-> !fundamental_reset_n)
    else $error("fundamental reset missed an input reset");
  // write reaches the mirror two cycles later
  alias_mirror_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R8
    cfg_req.wr && hit_sub && cfg_req.be == 4'hf ##1 fundamental_reset_n
      |=> {subsystem_device_alias, subsystem_vendor_alias} == $past(cfg_req.wdata, 2))
    else $error("subsystem alias not mirrored");
  // readback of subsystem register
  sub_readback_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R9
    cfg_req.rd && hit_sub |=> cfg_rdata == $past(sub_q))
    else $error("subsystem readback wrong");
  // mpeg qualification
  mpeg_apply_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R1
    mpeg_stamp_apply |-> $past(enh_q[lesar_bit_mpeg]) && $past(tx_fmt) == lesar_fmt_mpeg)
    else $error("mpeg enhancement applied wrongly");
  // dv qualification
  dv_apply_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R2
    $past(nrst) && $past(fundamental_reset_n) && $past(enh_q[lesar_bit_dv])
      && $past(tx_fmt) == lesar_fmt_dv |-> dv_stamp_apply)
    else $error("dv enhancement not applied");
  // enhancement bits clear after fundamental reset
  enh_reset_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    !fundamental_reset_n |=> enh_q == 32'h0)
    else $error("enhancement bits not reset");
  // priority and acceleration follow their bits
  prio_accel_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R3
    $past(nrst) && $past(fundamental_reset_n) |-> enh.prio_req_on == $past(enh_q[lesar_bit_prio])
      && enh.accel_on == $past(enh_q[lesar_bit_accel]))
    else $error("priority or acceleration control wrong");

  // every read strobe is answered by a data strobe one cycle later
  rvalid_on_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R9
    cfg_req.rd |=> cfg_rvalid)
    else $error("read strobe not answered");

  // no data strobe without a read strobe
  rvalid_off_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R9
    !cfg_req.rd |=> !cfg_rvalid)
    else $error("data strobe without a read");

  // enhancement read returns the stored writable bits
  enh_read_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R6
    cfg_req.rd && hit_enh |=> cfg_rdata == $past(enh_q))
    else $error("enhancement readback wrong");

  // reads of unmapped offsets return zero
  unmapped_read_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R9
    cfg_req.rd && !hit_enh && !hit_sub |=> cfg_rdata == 32'h0)
    else $error("unmapped read nonzero");

  // read-only enhancement bits never get stored
  enh_ro_clear_a: assert property (@(posedge clk) disable iff (!nrst) // R13
    (enh_q & ~lesar_enh_wmask) == 32'h0)
    else $error("read-only enhancement bit stored");

  // enhancement bits hold without a write to them
  enh_hold_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R11
    !(cfg_req.wr && hit_enh) |=> enh_q == $past(enh_q))
    else $error("enhancement bits changed without a write");

  // subsystem alias register holds without a write to it
  sub_hold_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R11
    !(cfg_req.wr && hit_sub) |=> sub_q == $past(sub_q))
    else $error("subsystem alias changed without a write");

  // full write to the enhancement register keeps only writable bits
  enh_write_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R13
    cfg_req.wr && hit_enh && cfg_req.be == 4'hf |=> enh_q == ($past(cfg_req.wdata) & lesar_enh_wmask))
    else $error("enhancement write stored wrongly");

  // a disabled lowest byte lane leaves the low enhancement bits alone
  enh_lane_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R13
    cfg_req.wr && hit_enh && !cfg_req.be[0] |=> enh_q[7:0] == $past(enh_q[7:0]))
    else $error("enhancement lane written without enable");

  // full write to the subsystem alias register stores the whole word
  sub_write_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R10
    cfg_req.wr && hit_sub && cfg_req.be == 4'hf |=> sub_q == $past(cfg_req.wdata))
    else $error("subsystem alias write stored wrongly");

  // a disabled top lane leaves the upper device alias byte alone
  sub_lane_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R10
    cfg_req.wr && hit_sub && !cfg_req.be[3] |=> sub_q[31:24] == $past(sub_q[31:24]))
    else $error("subsystem lane written without enable");

  // a write to the alias register pulses the update strobe
  upd_on_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R8
    cfg_req.wr && hit_sub |=> subsys_update)
    else $error("update strobe missing");

  // no update strobe without a write to the alias register
  upd_off_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R8
    !(cfg_req.wr && hit_sub) |=> !subsys_update)
    else $error("update strobe without a write");

  // device alias comes from the upper half
  dev_alias_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R10
    1'b1 |=> subsystem_device_alias == $past(sub_q[31:16]))
    else $error("device alias not from upper half");

  // vendor alias comes from the lower half
  ven_alias_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R10
    1'b1 |=> subsystem_vendor_alias == $past(sub_q[15:0]))
    else $error("vendor alias not from lower half");

  // fundamental reset lifts once both reset inputs are high
  fundamental_reset_n_release_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    pcie_reset_n && global_reset_n |=> fundamental_reset_n)
    else $error("fundamental reset stuck low");

  // link reset input alone asserts fundamental reset
  fundamental_reset_n_pcie_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    !pcie_reset_n |=> !fundamental_reset_n)
    else $error("link reset did not assert fundamental reset");

  // global reset input alone asserts fundamental reset
  fundamental_reset_n_global_a: assert property (@(posedge clk) disable iff (!nrst) // R12
    !global_reset_n |=> !fundamental_reset_n)
    else $error("global reset did not assert fundamental reset");

  // enabled mpeg bit with mpeg format applies the enhancement
  mpeg_on_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R1
    enh_q[lesar_bit_mpeg] && tx_fmt == lesar_fmt_mpeg |=> mpeg_stamp_apply)
    else $error("mpeg enhancement not applied");

  // dv enhancement stays off unless enabled and dv format
  dv_off_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R2
    !enh_q[lesar_bit_dv] || tx_fmt != lesar_fmt_dv |=> !dv_stamp_apply)
    else $error("dv enhancement applied wrongly");

  // mpeg enable control follows its stored bit
  mpeg_boost_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R1
    1'b1 |=> enh.mpeg_stamp_boost_on == $past(enh_q[lesar_bit_mpeg]))
    else $error("mpeg enable control wrong");

  // dv enable control follows its stored bit
  dv_boost_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R2
    1'b1 |=> enh.dv_stamp_boost_on == $past(enh_q[lesar_bit_dv]))
    else $error("dv enable control wrong");

  // acceleration notice follows its stored bit
  accel_follow_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R4
    1'b1 |=> enh.accel_on == $past(enh_q[lesar_bit_accel]))
    else $error("acceleration control wrong");

  // writable reserved bit is passed on as stored
  rsvd2_follow_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R5
    1'b1 |=> enh.rsvd2 == $past(enh_q[lesar_bit_rsvd2]))
    else $error("reserved control bit wrong");

  // fundamental reset clears every enhancement control
  ctrl_clear_a: assert property (@(posedge clk) disable iff (!nrst) // R7
    !fundamental_reset_n |=> enh == '0 && !mpeg_stamp_apply && !dv_stamp_apply)
    else $error("enhancement controls not cleared");

  // fundamental reset clears the alias register and its mirror
  sub_reset_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    !fundamental_reset_n |=> sub_q == 32'h0 && {subsystem_device_alias, subsystem_vendor_alias} == 32'h0)
    else $error("subsystem alias not cleared");

  // no strobes leave the block while fundamental reset is low
  strobe_quiet_a: assert property (@(posedge clk) disable iff (!nrst) // R11
    !fundamental_reset_n |=> !cfg_rvalid && !subsys_update)
    else $error("strobe during fundamental reset");

  // block reset holds fundamental reset and all strobes low
  nrst_clear_a: assert property (@(posedge clk) // R12
    !nrst |=> !fundamental_reset_n && !cfg_rvalid && !subsys_update)
    else $error("block reset did not clear outputs");

  // every read-only enhancement bit is clear in storage and on reads
  for (genvar b = 0; b < 32; b++) begin : g_ro_bit
    if (!lesar_enh_wmask[b]) begin : g_ro
      ro_bit_zero_a: assert property (@(posedge clk) disable iff (!nrst || !fundamental_reset_n) // R6
        cfg_req.rd && hit_enh |=> !cfg_rdata[b] && !enh_q[b])
        else $error("read-only enhancement bit set");
    end
  end
endmodule // lesar_regs

// ===== test_link_enhance_subsys_alias_regs.sv
// Purpose: self-checking bench for the link enhancement and subsystem alias registers
// Assumes: inputs change on the falling clock edge, one request at a time
// Notes: link enhancement register sits at the package offset
`timescale 1ns/1ps
module test_link_enhance_subsys_alias_regs import lesar_pkg::*;;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pcie_reset_n = 1'b1;
  logic global_reset_n = 1'b1;
  lesar_cfg_req_t req = '0;
  logic [7:0] tx_fmt = 8'h11;
  logic [31:0] rdata;
  logic rvalid, mpeg_ap, dv_ap, upd, fundamental_reset_n_n;
  lesar_enh_t enh;
  logic [15:0] dev_al, ven_al;
  int fails = 0;
  int total_checks = 0;
  int cycles = 0;

  // 4 ns clock
  always #2 clk = ~clk;

  lesar_regs dut (.clk(clk), .nrst(nrst), .pcie_reset_n(pcie_reset_n), .global_reset_n(global_reset_n),
    .cfg_req(req), .cfg_rdata(rdata), .cfg_rvalid(rvalid), .tx_fmt(tx_fmt), .enh(enh),
    .mpeg_stamp_apply(mpeg_ap), .dv_stamp_apply(dv_ap), .subsystem_device_alias(dev_al),
    .subsystem_vendor_alias(ven_al), .subsys_update(upd), .fundamental_reset_n(fundamental_reset_n_n));

  // compare and report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one configuration write, strobe held for one edge
  task wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge clk);
    req.wr = 1'b1;
    req.addr = a;
    req.be = b;
    req.wdata = d;
    @(negedge clk);
    req.wr = 1'b0;
  endtask
  // configuration read, bounded wait for the data strobe, then compare
  task rchk(input logic [11:0] a, input logic [31:0] e);
    int n;
    n = 0;
    @(negedge clk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk);
    req.rd = 1'b0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata, e);
  endtask
  task wait_fundamental_reset_n;
    int n;
    n = 0;
    while (fundamental_reset_n_n !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    chk({31'h0, fundamental_reset_n_n}, 32'h1);
  endtask
  task test_reset_values;
    rchk(lesar_ofs_link_enh, 32'h0);
    rchk(lesar_ofs_subsys, 32'h0);
    chk({27'h0, enh}, 32'h0);
    $display("test_reset_values done");
  endtask
  task test_link_enh;
    wr(lesar_ofs_link_enh, 4'hf, 32'hffff_fffb);
    rchk(lesar_ofs_link_enh, 32'h0000_0582);
    chk({27'h0, enh}, 32'h1e);
    tx_fmt = 8'h20;
    repeat (2) @(negedge clk);
    chk({30'h0, mpeg_ap, dv_ap}, 32'h2);
    tx_fmt = 8'h00;
    repeat (2) @(negedge clk);
    chk({30'h0, mpeg_ap, dv_ap}, 32'h1);
    wr(lesar_ofs_link_enh, 4'hf, 32'h0000_0480);
    rchk(lesar_ofs_link_enh, 32'h0000_0480);
    chk({27'h0, enh}, 32'h14);
    chk({30'h0, mpeg_ap, dv_ap}, 32'h0);
    wr(lesar_ofs_link_enh, 4'b0010, 32'h0);
    tx_fmt = 8'h20;
    rchk(lesar_ofs_link_enh, 32'h0000_0080);
    chk({30'h0, mpeg_ap, dv_ap}, 32'h0);
    $display("test_link_enh done");
  endtask
  task test_subsys;
    wr(lesar_ofs_subsys, 4'hf, 32'h1234_5678);
    chk({31'h0, upd}, 32'h1);
    @(negedge clk);
    chk({31'h0, upd}, 32'h0);
    chk({dev_al, ven_al}, 32'h1234_5678);
    wr(lesar_ofs_subsys, 4'b0101, 32'haaaa_bbbb);
    rchk(lesar_ofs_subsys, 32'h12aa_56bb);
    chk({dev_al, ven_al}, 32'h12aa_56bb);
    wr(12'h0fc, 4'hf, 32'hffff_ffff);
    rchk(12'h0fc, 32'h0);
    rchk(lesar_ofs_subsys, 32'h12aa_56bb);
    $display("test_subsys done");
  endtask
  // either reset input clears both registers
  task test_fund_reset(input logic use_global);
    wr(lesar_ofs_subsys, 4'hf, 32'hcafe_0001);
    wr(lesar_ofs_link_enh, 4'hf, 32'h0000_0102);
    @(negedge clk);
    if (use_global) begin
      global_reset_n = 1'b0;
    end else begin
      pcie_reset_n = 1'b0;
    end
    repeat (2) @(negedge clk);
    chk({31'h0, fundamental_reset_n_n}, 32'h0);
    global_reset_n = 1'b1;
    pcie_reset_n = 1'b1;
    @(negedge clk);
    wait_fundamental_reset_n();
    rchk(lesar_ofs_subsys, 32'h0);
    rchk(lesar_ofs_link_enh, 32'h0);
    $display("test_fund_reset done");
  endtask
  task end_of_test;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end

  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    wait_fundamental_reset_n();
    test_reset_values();
    test_link_enh();
    test_subsys();
    test_fund_reset(1'b0);
    test_fund_reset(1'b1);
    end_of_test();
  end
endmodule // test_link_enhance_subsys_alias_regs
